// *** design/uwb_pkg.sv ***
// Shared constants, types and helpers for the serial port block
`default_nettype none
package uwb_pkg;
   localparam int CLK_HZ = 250_000_000;
   localparam int CLK_PERIOD_NS = 4;
   // Rate = divisor / 0.004096 s, the scale kept in microseconds
   localparam int BAUD_SCALE_US = 4096;
   localparam int BAUD_MODULUS = CLK_HZ / 1_000_000 * BAUD_SCALE_US;
   localparam int OVERSAMPLE = 16;
   localparam int ACC_W = 21;
   localparam logic [20:0] BAUD_MOD_V = 21'(BAUD_MODULUS);
   localparam int MIN_RATE_BPS = 1200;
   localparam int MAX_RATE_BPS = 3_000_000;
   localparam logic [15:0] DIV_MIN = 16'h0005;
   localparam logic [15:0] DIV_MAX = 16'h3000;
   localparam logic [15:0] DIV_9600 = 16'h0027;
   localparam logic [15:0] DIV_115200 = 16'h01d8;
   localparam logic [15:0] DIV_921600 = 16'h0ebf;
   localparam logic [15:0] BREAK_TIMEOUT_KEY_ID = 16'h01a4;
   localparam int BREAK_UNIT_MS = 1;
   localparam int MS_CYCLES = CLK_HZ / 1000 * BREAK_UNIT_MS;
   localparam int DATA_BITS = 8;
   localparam logic [3:0] SAMPLE_MID = 4'h7;
   localparam logic [3:0] SAMPLE_END = 4'hf;
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic [3:0] GP_RESET = 4'hf;

   typedef enum logic [1:0] {
      UWB_PAR_NONE = 2'b00,
      UWB_PAR_ODD = 2'b01,
      UWB_PAR_EVEN = 2'b10
   } uwb_parity_t;

   function automatic logic uwb_par_bit(input logic [7:0] data, input logic [1:0] mode);
      uwb_par_bit = (^data) ^ (mode == UWB_PAR_ODD);
   endfunction

   function automatic logic uwb_par_on(input logic [1:0] mode);
      uwb_par_on = (mode == UWB_PAR_ODD) || (mode == UWB_PAR_EVEN);
   endfunction
endpackage
`default_nettype wire

// *** design/uwb_bit_if.sv ***
// Link between the top level and the receiver
`timescale 1ns/1ps
`default_nettype none
interface uwb_bit_if;
   logic tick16;
   logic line;
   logic [1:0] parity_mode;
   logic [7:0] data;
   logic valid;
   logic perr;
   logic ferr;
   modport rx (input tick16, line, parity_mode, output data, valid, perr, ferr);
   modport top (output tick16, line, parity_mode, input data, valid, perr, ferr);
endinterface
`default_nettype wire

// *** design/uwb_rx.sv ***
// Serial receiver with centre sampling and error flags
`timescale 1ns/1ps
`default_nettype none
module uwb_rx (
   input wire logic clk_sys,
   input wire logic rst,
   uwb_bit_if.rx bus
);
   typedef enum logic [2:0] {
      UWB_RX_IDLE = 3'b000,
      UWB_RX_START = 3'b001,
      UWB_RX_DATA = 3'b010,
      UWB_RX_PAR = 3'b011,
      UWB_RX_STOP = 3'b100
   } uwb_rx_state_t;

   uwb_rx_state_t state;
   logic [3:0] cnt;
   logic [3:0] bitn;
   logic [7:0] shift;
   logic perr_hold;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= UWB_RX_IDLE;
         cnt <= 4'h0;
         bitn <= 4'h0;
         shift <= 8'h00;
         perr_hold <= 1'b0;
         bus.data <= 8'h00;
         bus.valid <= 1'b0;
         bus.perr <= 1'b0;
         bus.ferr <= 1'b0;
      end else begin
         bus.valid <= 1'b0;
         if (bus.tick16) begin
            cnt <= cnt + 4'h1;
            unique case (state)
               UWB_RX_IDLE: begin
                  cnt <= 4'h0;
                  if (!bus.line) begin
                     state <= UWB_RX_START;
                  end
               end
               UWB_RX_START: begin
                  // Half a bit in, so later samples land at bit centres
                  if (cnt == uwb_pkg::SAMPLE_MID) begin
                     cnt <= 4'h0;
                     bitn <= 4'h0;
                     state <= bus.line ? UWB_RX_IDLE : UWB_RX_DATA;
                  end
               end
               UWB_RX_DATA: begin
                  if (cnt == uwb_pkg::SAMPLE_END) begin
                     shift <= {bus.line, shift[7:1]};
                     bitn <= bitn + 4'h1;
                     if (bitn == uwb_pkg::LAST_BIT) begin
                        perr_hold <= 1'b0;
                        state <= uwb_pkg::uwb_par_on(bus.parity_mode) ? UWB_RX_PAR : UWB_RX_STOP;
                     end
                  end
               end
               UWB_RX_PAR: begin
                  if (cnt == uwb_pkg::SAMPLE_END) begin
                     perr_hold <= bus.line != uwb_pkg::uwb_par_bit(shift, bus.parity_mode);
                     state <= UWB_RX_STOP;
                  end
               end
               UWB_RX_STOP: begin
                  if (cnt == uwb_pkg::SAMPLE_END) begin
                     bus.data <= shift;
                     bus.valid <= 1'b1;
                     bus.perr <= perr_hold;
                     bus.ferr <= !bus.line;
                     state <= UWB_RX_IDLE;
                  end
               end
               default: state <= UWB_RX_IDLE;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// *** design/uwb_top.sv ***
// Serial port with break reset, break send and pin bypass
//
// Contract
// - Data moves on one receive and one transmit line, with two optional flow lines.
// - Request-to-send and clear-to-send are both active low.
// - Any rate from 1200 bit/s to 3 Mbit/s is set by a stored divisor; the code clamps the divisor to 0x0005 at least, about 1221 bit/s.
// - The bit rate equals the divisor divided by 0.004096.
// - Tabulated divisors such as 0x01d8 and 0x0ebf give the standard rates.
// - Characters have 8 data bits, none/odd/even parity, 1 or 2 stops, RTS/CTS or none.
// - A receive line held low longer than the timeout resets the chip.
// - The port can send a break to wake the host.
// - All port outputs float while the chip is in reset.
// - After reset the host bus talks to this port.
// - The bypass command routes the host bus to general purpose pins 3 to 0.
// - After bypass the device sleeps deeply until reset.
`timescale 1ns/1ps
`default_nettype none
module uwb_top #(
   parameter int MS_CYCLES = uwb_pkg::MS_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [15:0] baud_divisor_key,
   input wire logic [1:0] parity_mode,
   input wire logic two_stop,
   input wire logic flow_en,
   input wire logic [15:0] break_reset_timeout_key,
   input wire logic uart_rx_pin,
   input wire logic uart_cts_n_pin,
   output logic uart_tx_o,
   output logic uart_tx_oe,
   output logic uart_rts_n_o,
   output logic uart_rts_n_oe,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic send_break,
   output logic [7:0] rx_data,
   output logic rx_valid,
   output logic rx_parity_err,
   output logic rx_frame_err,
   input wire logic rx_ready,
   output logic chip_reset_req,
   input wire logic bypass_cmd,
   output logic deep_sleep,
   input wire logic [3:0] general_purpose_pin_i,
   output logic [3:0] general_purpose_pin_o,
   output logic [3:0] general_purpose_pin_oe
);
   typedef enum logic [2:0] {
      UWB_TX_IDLE = 3'b000,
      UWB_TX_START = 3'b001,
      UWB_TX_DATA = 3'b010,
      UWB_TX_PAR = 3'b011,
      UWB_TX_STOP = 3'b100,
      UWB_TX_BRK = 3'b101
   } uwb_tx_state_t;

   uwb_bit_if link ();

   // Pin synchronisers: rx, cts, bypass tx source, bypass rts source
   logic [3:0] sync1;
   logic [3:0] sync2;
   logic rx_s;
   logic cts_n_s;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sync1 <= uwb_pkg::GP_RESET;
         sync2 <= uwb_pkg::GP_RESET;
      end else begin
         sync1 <= {general_purpose_pin_i[3], general_purpose_pin_i[1], uart_cts_n_pin, uart_rx_pin};
         sync2 <= sync1;
      end
   end
   assign rx_s = sync2[0];
   assign cts_n_s = sync2[1];

   // Out-of-range divisors are clamped to the supported band
   logic [15:0] div_eff;
   always_comb begin
      div_eff = baud_divisor_key;
      if (baud_divisor_key < uwb_pkg::DIV_MIN) begin
         div_eff = uwb_pkg::DIV_MIN;
      end else if (baud_divisor_key > uwb_pkg::DIV_MAX) begin
         div_eff = uwb_pkg::DIV_MAX;
      end
   end

   // Phase accumulator: 16 ticks per bit at divisor/0.004096 bit/s, no cumulative drift
   logic [20:0] acc;
   logic [20:0] acc_sum;
   logic tick16;
   assign acc_sum = acc + {1'b0, div_eff, 4'h0};
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         acc <= 21'h00_0000;
         tick16 <= 1'b0;
      end else if (acc_sum >= uwb_pkg::BAUD_MOD_V) begin
         acc <= acc_sum - uwb_pkg::BAUD_MOD_V;
         tick16 <= 1'b1;
      end else begin
         acc <= acc_sum;
         tick16 <= 1'b0;
      end
   end

   logic bypass;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         bypass <= 1'b0;
      end else if (bypass_cmd) begin
         bypass <= 1'b1;
      end
   end
   assign deep_sleep = bypass;

   assign link.tick16 = tick16 && !bypass;
   assign link.line = rx_s;
   assign link.parity_mode = parity_mode;
   uwb_rx u_rx (
      .clk_sys(clk_sys),
      .rst(rst),
      .bus(link)
   );
   assign rx_data = link.data;
   assign rx_valid = link.valid;
   assign rx_parity_err = link.perr;
   assign rx_frame_err = link.ferr;

   // Transmitter
   uwb_tx_state_t tx_state;
   logic [3:0] tx_cnt;
   logic [3:0] tx_bitn;
   logic [7:0] tx_shift;
   logic tx_par;
   logic tx_line;
   logic stop_second;
   logic cts_ok;
   assign cts_ok = !flow_en || !cts_n_s;
   assign tx_ready = (tx_state == UWB_TX_IDLE) && !send_break && cts_ok && !bypass;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tx_state <= UWB_TX_IDLE;
         tx_cnt <= 4'h0;
         tx_bitn <= 4'h0;
         tx_shift <= 8'h00;
         tx_par <= 1'b0;
         tx_line <= 1'b1;
         stop_second <= 1'b0;
      end else if (tx_state == UWB_TX_IDLE) begin
         tx_cnt <= 4'h0;
         tx_line <= 1'b1;
         if (!bypass && send_break) begin
            tx_state <= UWB_TX_BRK;
            tx_line <= 1'b0;
         end else if (tx_valid && tx_ready) begin
            tx_shift <= tx_data;
            tx_par <= uwb_pkg::uwb_par_bit(tx_data, parity_mode);
            tx_state <= UWB_TX_START;
            tx_line <= 1'b0;
         end
      end else if (tick16) begin
         tx_cnt <= tx_cnt + 4'h1;
         if (tx_cnt == uwb_pkg::SAMPLE_END) begin
            unique case (tx_state)
               UWB_TX_START: begin
                  tx_state <= UWB_TX_DATA;
                  tx_bitn <= 4'h0;
                  tx_line <= tx_shift[0];
               end
               UWB_TX_DATA: begin
                  tx_bitn <= tx_bitn + 4'h1;
                  tx_shift <= {1'b1, tx_shift[7:1]};
                  if (tx_bitn == uwb_pkg::LAST_BIT) begin
                     stop_second <= 1'b0;
                     if (uwb_pkg::uwb_par_on(parity_mode)) begin
                        tx_state <= UWB_TX_PAR;
                        tx_line <= tx_par;
                     end else begin
                        tx_state <= UWB_TX_STOP;
                        tx_line <= 1'b1;
                     end
                  end else begin
                     tx_line <= tx_shift[1];
                  end
               end
               UWB_TX_PAR: begin
                  tx_state <= UWB_TX_STOP;
                  tx_line <= 1'b1;
               end
               UWB_TX_STOP: begin
                  if (two_stop && !stop_second) begin
                     stop_second <= 1'b1;
                  end else begin
                     tx_state <= UWB_TX_IDLE;
                  end
               end
               UWB_TX_BRK: begin
                  // Held low at least one bit; a high stop bit follows the release
                  if (!send_break) begin
                     tx_state <= UWB_TX_STOP;
                     stop_second <= 1'b1;
                     tx_line <= 1'b1;
                  end
               end
               default: tx_state <= UWB_TX_IDLE;
            endcase
         end
      end
   end

   // Pin drivers; enables stay low through reset so the bus may be shared
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         uart_tx_oe <= 1'b0;
         uart_rts_n_oe <= 1'b0;
         uart_tx_o <= 1'b1;
         uart_rts_n_o <= 1'b1;
         general_purpose_pin_o <= uwb_pkg::GP_RESET;
         general_purpose_pin_oe <= 4'h0;
      end else begin
         uart_tx_oe <= 1'b1;
         uart_rts_n_oe <= 1'b1;
         if (bypass) begin
            uart_tx_o <= sync2[2];
            uart_rts_n_o <= sync2[3];
            general_purpose_pin_o <= {1'b1, cts_n_s, 1'b1, rx_s};
            general_purpose_pin_oe <= 4'h5;
         end else begin
            uart_tx_o <= tx_line;
            uart_rts_n_o <= flow_en ? !rx_ready : 1'b0;
            general_purpose_pin_o <= uwb_pkg::GP_RESET;
            general_purpose_pin_oe <= 4'h0;
         end
      end
   end

   // Break detector: low time in milliseconds, restarted by any high level
   logic [17:0] ms_cnt;
   logic [15:0] brk_ms;
   logic brk_fired;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ms_cnt <= 18'h0_0000;
         brk_ms <= 16'h0000;
         brk_fired <= 1'b0;
         chip_reset_req <= 1'b0;
      end else begin
         chip_reset_req <= 1'b0;
         if (rx_s || bypass) begin
            ms_cnt <= 18'h0_0000;
            brk_ms <= 16'h0000;
            brk_fired <= 1'b0;
         end else begin
            if (ms_cnt == 18'(MS_CYCLES - 1)) begin
               ms_cnt <= 18'h0_0000;
               if (brk_ms != 16'hffff) begin
                  brk_ms <= brk_ms + 16'h0001;
               end
            end else begin
               ms_cnt <= ms_cnt + 18'h0_0001;
            end
            // Zero timeout disables break reset
            if (!brk_fired && break_reset_timeout_key != 16'h0000
                  && brk_ms > break_reset_timeout_key) begin
               chip_reset_req <= 1'b1;
               brk_fired <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** verif/uwb_props.sv ***
// Port checker for the serial port block
`timescale 1ns/1ps
`default_nettype none
module uwb_props #(
   parameter int MS_CYCLES = 25
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic flow_en,
   input wire logic [15:0] break_reset_timeout_key,
   input wire logic uart_rx_pin,
   input wire logic uart_cts_n_pin,
   input wire logic uart_tx_o,
   input wire logic uart_tx_oe,
   input wire logic uart_rts_n_o,
   input wire logic uart_rts_n_oe,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic send_break,
   input wire logic rx_valid,
   input wire logic rx_parity_err,
   input wire logic rx_ready,
   input wire logic chip_reset_req,
   input wire logic bypass_cmd,
   input wire logic deep_sleep,
   input wire logic [3:0] general_purpose_pin_i,
   input wire logic [3:0] general_purpose_pin_o,
   input wire logic [3:0] general_purpose_pin_oe
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   int low_cnt;
   logic fired;
   // Raw low time of the receive line, so sync latency only makes it longer
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         low_cnt <= 0;
         fired <= 1'b0;
      end else if (uart_rx_pin) begin
         low_cnt <= 0;
         fired <= 1'b0;
      end else begin
         low_cnt <= low_cnt + 1;
         fired <= fired | chip_reset_req;
      end
   end
   a_float_reset: assert property (disable iff (1'b0)
      rst |-> !uart_tx_oe && !uart_rts_n_oe && general_purpose_pin_oe == 4'h0)
      else $error("port driven during reset");
   a_drive_after: assert property (
      !deep_sleep && !$past(rst) |-> uart_tx_oe && uart_rts_n_oe)
      else $error("port not driven after reset");
   a_rts_level: assert property (
      !deep_sleep && !$past(deep_sleep) && !$past(rst)
      |-> uart_rts_n_o == ($past(flow_en) && !$past(rx_ready)))
      else $error("request-to-send level wrong");
   a_cts_block: assert property (
      (flow_en && uart_cts_n_pin) [*3] |-> !tx_ready)
      else $error("send allowed without clear-to-send");
   a_tx_start: assert property (
      tx_valid && tx_ready |-> ##1 uart_tx_o ##2 !uart_tx_o)
      else $error("start bit not on time");
   a_break_drive: assert property (
      $past(tx_ready) && $rose(send_break) && !deep_sleep |-> ##3 !uart_tx_o)
      else $error("break not driven");
   a_break_late: assert property (
      chip_reset_req |-> low_cnt > break_reset_timeout_key * MS_CYCLES)
      else $error("reset request too early");
   a_break_miss: assert property (
      low_cnt == (break_reset_timeout_key + 2) * MS_CYCLES + 4
      && break_reset_timeout_key != 16'h0000 && !deep_sleep |-> fired)
      else $error("reset request missing");
   a_break_once: assert property (
      chip_reset_req |-> !fired && !deep_sleep && break_reset_timeout_key != 16'h0000)
      else $error("extra reset request");
   a_bypass_enter: assert property (
      bypass_cmd |=> deep_sleep)
      else $error("bypass not entered");
   a_sleep_stays: assert property (
      deep_sleep |=> deep_sleep && !rx_valid && !chip_reset_req && !tx_ready)
      else $error("sleep left or port active");
   a_bypass_route: assert property (
      deep_sleep ##0 ($stable({uart_rx_pin, uart_cts_n_pin, general_purpose_pin_i})) [*5]
      |-> general_purpose_pin_o[0] == uart_rx_pin && general_purpose_pin_o[2] == uart_cts_n_pin
      && uart_tx_o == general_purpose_pin_i[1] && uart_rts_n_o == general_purpose_pin_i[3]
      && general_purpose_pin_oe == 4'h5)
      else $error("bypass routing wrong");
   c_parity: cover property (rx_valid && rx_parity_err);
   c_reset_req: cover property (chip_reset_req);
   c_bypass: cover property (deep_sleep && general_purpose_pin_oe == 4'h5);
endmodule
bind uwb_top uwb_props #(.MS_CYCLES(MS_CYCLES)) u_props (
   .clk_sys(clk_sys), .rst(rst), .flow_en(flow_en),
   .break_reset_timeout_key(break_reset_timeout_key),
   .uart_rx_pin(uart_rx_pin), .uart_cts_n_pin(uart_cts_n_pin),
   .uart_tx_o(uart_tx_o), .uart_tx_oe(uart_tx_oe),
   .uart_rts_n_o(uart_rts_n_o), .uart_rts_n_oe(uart_rts_n_oe),
   .tx_valid(tx_valid), .tx_ready(tx_ready), .send_break(send_break),
   .rx_valid(rx_valid), .rx_parity_err(rx_parity_err), .rx_ready(rx_ready),
   .chip_reset_req(chip_reset_req), .bypass_cmd(bypass_cmd), .deep_sleep(deep_sleep),
   .general_purpose_pin_i(general_purpose_pin_i),
   .general_purpose_pin_o(general_purpose_pin_o),
   .general_purpose_pin_oe(general_purpose_pin_oe)
);
`default_nettype wire

// *** verif/uwb_host_model.sv ***
// Far-side serial device: frame sender and transmit line decoder
`timescale 1ns/1ps
`default_nettype none
module uwb_host_model (
   input wire logic [1:0] parity_mode,
   input wire logic from_dev,
   output logic to_dev,
   output logic [8:0] got,
   output logic got_stb
);
   real bit_ns = 333.333;
   initial begin
      to_dev = 1'b1;
      got = 9'h000;
      got_stb = 1'b0;
   end
   // Parity and stop can be spoilt on purpose to provoke error flags
   task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
      to_dev = 1'b0;
      #(bit_ns);
      for (int i = 0; i < 8; i++) begin
         to_dev = d[i];
         #(bit_ns);
      end
      if (parity_mode == 2'b01 || parity_mode == 2'b10) begin
         to_dev = (^d) ^ (parity_mode == 2'b01) ^ bad_par;
         #(bit_ns);
      end
      to_dev = !bad_stop;
      #(bit_ns);
      to_dev = 1'b1;
      #(bit_ns);
   endtask
   task automatic hold(input logic v, input real ns);
      to_dev = v;
      #(ns);
   endtask
   // got[8] is high when parity and first stop bit are good
   always begin
      @(negedge from_dev);
      #(bit_ns * 1.5);
      for (int i = 0; i < 8; i++) begin
         got[i] = from_dev;
         #(bit_ns);
      end
      got[8] = 1'b1;
      if (parity_mode == 2'b01 || parity_mode == 2'b10) begin
         got[8] = from_dev == ((^got[7:0]) ^ (parity_mode == 2'b01));
         #(bit_ns);
      end
      got[8] = got[8] & from_dev;
      got_stb = 1'b1;
      #1 got_stb = 1'b0;
   end
endmodule
`default_nettype wire

// *** verif/test_uwb_top.sv ***
// Self-checking bench for the serial port block
`timescale 1ns/1ps
`default_nettype none
module test_uwb_top;
   logic clk_sys = 1'b0, rst = 1'b0, two_stop = 1'b0, flow_en = 1'b0, uart_cts_n_pin = 1'b0;
   logic tx_valid = 1'b0, send_break = 1'b0, rx_ready = 1'b1, bypass_cmd = 1'b0, ign = 1'b0;
   logic [15:0] baud_divisor_key = 16'h3000, break_reset_timeout_key = 16'h0000;
   logic [1:0] parity_mode = 2'b00;
   logic [7:0] tx_data = 8'h00, rx_data;
   logic [3:0] general_purpose_pin_i = 4'h0, general_purpose_pin_o, general_purpose_pin_oe;
   logic uart_rx_pin, uart_tx_o, uart_tx_oe, uart_rts_n_o, uart_rts_n_oe, tx_ready, rx_valid;
   logic rx_parity_err, rx_frame_err, chip_reset_req, deep_sleep, tx_wire, got_stb;
   logic [8:0] got;
   logic [31:0] seed = 32'h0000_18af;
   logic [15:0] divs[2] = '{16'h3000, uwb_pkg::DIV_921600};
   logic [9:0] q_rx[$];
   logic [8:0] q_tx[$];
   int err_count = 0, tests_run = 0, pulses = 0;
   always #2 clk_sys = ~clk_sys;
   // A released transmit line rests high on its pull-up; no other party drives it
   assign tx_wire = uart_tx_oe ? uart_tx_o : 1'b1;
   uwb_top #(.MS_CYCLES(25)) u_dut (
      .clk_sys(clk_sys), .rst(rst), .baud_divisor_key(baud_divisor_key),
      .parity_mode(parity_mode), .two_stop(two_stop), .flow_en(flow_en),
      .break_reset_timeout_key(break_reset_timeout_key),
      .uart_rx_pin(uart_rx_pin), .uart_cts_n_pin(uart_cts_n_pin),
      .uart_tx_o(uart_tx_o), .uart_tx_oe(uart_tx_oe),
      .uart_rts_n_o(uart_rts_n_o), .uart_rts_n_oe(uart_rts_n_oe),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .send_break(send_break),
      .rx_data(rx_data), .rx_valid(rx_valid), .rx_parity_err(rx_parity_err),
      .rx_frame_err(rx_frame_err), .rx_ready(rx_ready), .chip_reset_req(chip_reset_req),
      .bypass_cmd(bypass_cmd), .deep_sleep(deep_sleep),
      .general_purpose_pin_i(general_purpose_pin_i),
      .general_purpose_pin_o(general_purpose_pin_o),
      .general_purpose_pin_oe(general_purpose_pin_oe)
   );
   uwb_host_model u_host (.parity_mode(parity_mode), .from_dev(tx_wire), .to_dev(uart_rx_pin),
      .got(got), .got_stb(got_stb));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // Holds valid until taken, then lets an edge pass so a following call never clashes
   task automatic put(input logic [7:0] d);
      int n;
      n = 0;
      tx_data <= d;
      tx_valid <= 1'b1;
      q_tx.push_back({1'b1, d});
      do begin
         @(posedge clk_sys);
         n++;
      end while (tx_ready !== 1'b1 && n < 20000);
      if (tx_ready !== 1'b1) err_count++;
      tx_valid <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rcv(input logic [7:0] d, input logic bp, input logic bs);
      q_rx.push_back({d, bp, bs});
      u_host.send(d, bp, bs);
   endtask
   always @(posedge clk_sys) begin
      if (chip_reset_req === 1'b1) pulses++;
      if (rx_valid === 1'b1 && !ign)
         chk({rx_data, rx_parity_err, rx_frame_err}, q_rx.size() ? q_rx.pop_front() : 10'h3ff);
   end
   always @(posedge got_stb) begin
      if (!ign) chk(got, q_tx.size() ? q_tx.pop_front() : 9'h1ff);
   end
   initial begin
      #400_000;
      err_count++;
      test_done;
   end
   initial begin
      // A real edge on reset, so the pins float from time zero
      rst <= 1'b1;
      cyc(10);
      chk({uart_tx_oe, uart_rts_n_oe, general_purpose_pin_oe}, 16'h0000);
      rst <= 1'b0;
      cyc(3);
      chk({uart_tx_oe, uart_rts_n_oe, deep_sleep}, 16'h0006);
      foreach (divs[j]) begin
         cyc(1);
         baud_divisor_key <= divs[j];
         u_host.bit_ns = 4096000.0 / divs[j];
         for (int m = 0; m < 4; m++) begin
            cyc(1);
            parity_mode <= m[1:0];
            two_stop <= m[0];
            cyc(2);
            seed = xs(seed);
            put(seed[7:0]);
            put(seed[15:8]);
            rcv(seed[23:16], 1'b0, 1'b0);
            rcv(seed[31:24], m == 1 || m == 2, m == 3);
         end
         $display("rate %h done", divs[j]);
      end
      cyc(1);
      baud_divisor_key <= 16'h3000;
      u_host.bit_ns = 4096000.0 / 16'h3000;
      flow_en <= 1'b1;
      uart_cts_n_pin <= 1'b1;
      rx_ready <= 1'b0;
      // Let the blocked clear-to-send pass the synchroniser before offering a byte
      cyc(3);
      fork
         put(8'ha5);
         begin
            cyc(50);
            chk({tx_ready, uart_tx_o, uart_rts_n_o}, 16'h0003);
            uart_cts_n_pin <= 1'b0;
         end
      join
      rx_ready <= 1'b1;
      cyc(3);
      chk(uart_rts_n_o, 16'h0000);
      cyc(1200);
      flow_en <= 1'b0;
      send_break <= 1'b1;
      q_tx.push_back(9'h000);
      cyc(1200);
      send_break <= 1'b0;
      cyc(1200);
      $display("transmit, receive, flow and break send done");
      break_reset_timeout_key <= 16'h0003;
      ign = 1'b1;
      u_host.hold(1'b0, 600.0);
      u_host.hold(1'b1, 4000.0);
      chk(pulses, 16'h0001);
      u_host.hold(1'b0, 360.0);
      u_host.hold(1'b1, 40.0);
      u_host.hold(1'b0, 360.0);
      u_host.hold(1'b1, 4000.0);
      chk(pulses, 16'h0001);
      @(posedge clk_sys);
      break_reset_timeout_key <= 16'h0000;
      u_host.hold(1'b0, 1200.0);
      u_host.hold(1'b1, 4000.0);
      chk(pulses, 16'h0001);
      $display("break reset done");
      @(posedge clk_sys);
      // The model holds no radio links, so bypass may be asked at once
      bypass_cmd <= 1'b1;
      @(posedge clk_sys);
      bypass_cmd <= 1'b0;
      for (int k = 0; k < 8; k++) begin
         seed = xs(seed);
         general_purpose_pin_i <= seed[3:0];
         uart_cts_n_pin <= seed[4];
         u_host.hold(seed[5], 40.0);
         chk({general_purpose_pin_o[2], general_purpose_pin_o[0], uart_tx_o, uart_rts_n_o,
            general_purpose_pin_oe}, {seed[4], seed[5], seed[1], seed[3], 4'h5});
      end
      chk({deep_sleep, tx_ready, pulses[1:0]}, 16'h0009);
      u_host.hold(1'b1, 40.0);
      uart_cts_n_pin <= 1'b0;
      rst <= 1'b1;
      cyc(3);
      rst <= 1'b0;
      cyc(5);
      chk({deep_sleep, uart_tx_oe, general_purpose_pin_oe}, 16'h0010);
      cyc(1000);
      ign = 1'b0;
      $display("bypass and second reset done");
      chk(q_tx.size() + q_rx.size(), 16'h0000);
      test_done;
   end
endmodule
`default_nettype wire
